/* logic/htl_logger.sv */
// Histogram temperature logger controller
//
// Overview of operation
// - Each bin upper limit is a signed 8.5 value in the low 13 bits of its word.
// - Bin enable mask has one bit per bin, bit i enabling bin i.
// - Each bin interval word counts seconds between acquisitions.
// - A sample is stored to the log only if its bin's store flag is set.
// - A timestamp goes with a stored sample only if its bin's stamp flag is set.
// - A nonzero initial date followed by the reset bit moves the device to idle.
// - In idle the clock runs and no sampling happens until logging is enabled.
// - After enable, wait the start delay if enabled and nonzero, else start.
// - The next sample is timed by the interval of the last sample's bin, or one second if it hit no bin.
// - A counter above its threshold sets its bin alarm bit and the summary flag.
// - A bin counter increments for each sample falling in that bin.
// - Status bits 1:0 report battery level, three full, zero minimum.
// - A full log sets the memory-full bit and the device goes to sleep.
`timescale 1ns/1ps
module htl_logger
   import htl_pkg::*;
#(
   parameter int NB        = htl_pkg::NUM_BINS,
   parameter int DEPTH     = htl_pkg::LOG_DEPTH,
   parameter int CYC_SEC   = htl_pkg::CYC_PER_SEC
) (
   input  wire logic                    ref_clk_i,
   input  wire logic                    rst_i,
   input  wire logic [31:0]             init_date_i,
   input  wire logic                    ctrl_reset_i,
   input  wire logic                    logging_enable_bit_i,
   input  wire logic                    delay_enable_i,
   input  wire logic [15:0]             start_delay_s_i,
   input  wire logic [NB-1:0]           bin_enable_i,
   input  wire logic [NB-1:0]           bin_store_i,
   input  wire logic [NB-1:0]           bin_stamp_i,
   input  wire logic [NB*16-1:0]        bin_upper_limit_i,
   input  wire logic [NB*16-1:0]        bin_threshold_i,
   input  wire logic [NB*16-1:0]        bin_interval_seconds_i,
   input  wire logic [1:0]              battery_level_i,
   input  wire logic signed [15:0]      temp_i,
   output logic                         temp_req_o,
   output logic                         log_we_o,
   output logic [15:0]                  log_data_o,
   output logic                         log_stamp_we_o,
   output logic [31:0]                  log_stamp_o,
   output logic [15:0]                  samples_num_o,
   output logic [15:0]                  status_o,
   output logic [NB-1:0]                histogram_alarm_word_o,
   output logic [NB*16-1:0]             bin_counter_o,
   output logic [15:0]                  last_sample_o,
   output logic [2:0]                   state_o
);
   import htl_pkg::*;

   localparam int BW = $clog2(NB);

   // Refused at elaboration, counters are one word each
   if (NB < 2 || NB > 16) $error("NB must be 2..16");
   if (DEPTH < 1 || DEPTH > 65535) $error("DEPTH out of range");
   if (CYC_SEC < 2) $error("CYC_SEC too small");

   typedef struct packed {
      htl_state_t       st;
      logic [31:0]      sub;
      logic [31:0]      now;
      logic [15:0]      secs;
      logic             req;
      logic             we;
      logic [15:0]      data;
      logic             swe;
      logic [31:0]      stamp;
      logic [15:0]      nsamp;
      logic             full;
      logic             halarm;
      logic [NB-1:0]    balarm;
      logic [NB*16-1:0] cnt;
      logic [15:0]      last;
      logic [1:0]       bat;
   } htl_regs_t;

   htl_regs_t r;
   htl_regs_t next_r;

   logic          hit;
   logic [BW-1:0] bin;

   function automatic logic [15:0] word_at(input logic [NB*16-1:0] v,
                                           input logic [BW-1:0] i);
      word_at = v[i*16 +: 16];
   endfunction

   htl_bin_classify #(.NB(NB), .W(16)) u_cls (
      .sample_i (temp_i),
      .limits_i (bin_upper_limit_i),
      .enable_i (bin_enable_i),
      .hit_o    (hit),
      .bin_o    (bin)
   );

   always_comb begin
      next_r     = r;
      next_r.req = 1'b0;
      next_r.we  = 1'b0;
      next_r.swe = 1'b0;
      next_r.bat = battery_level_i;
      if (r.st != HTL_INACTIVE) begin
         if (r.sub == 32'(CYC_SEC - 1)) begin
            next_r.sub = '0;
            next_r.now = r.now + 32'h0000_0001;
         end else begin
            next_r.sub = r.sub + 32'h0000_0001;
         end
      end
      case (r.st)
         HTL_INACTIVE: begin
            if (ctrl_reset_i && init_date_i != 32'h0000_0000) begin
               next_r.st  = HTL_IDLE;
               next_r.now = init_date_i;
               next_r.sub = '0;
            end
         end
         HTL_IDLE: begin
            if (logging_enable_bit_i) begin
               if (delay_enable_i && start_delay_s_i != WORD_ZERO) begin
                  next_r.st   = HTL_DELAY;
                  next_r.secs = start_delay_s_i;
               end else begin
                  next_r.st   = HTL_ACQUIRE;
                  next_r.secs = WORD_ZERO;
               end
            end
         end
         HTL_DELAY, HTL_ACQUIRE: begin
            if (!logging_enable_bit_i) begin
               next_r.st = HTL_IDLE;
            end else if (r.sub == 32'(CYC_SEC - 1) && r.secs != WORD_ZERO) begin
               next_r.secs = r.secs - 16'h0001;
            end else if (r.secs == WORD_ZERO && r.sub == '0) begin
               if (r.st == HTL_DELAY) begin
                  next_r.st = HTL_ACQUIRE;
               end else begin
                  next_r.req  = 1'b1;
                  next_r.last = temp_i;
                  next_r.secs = 16'h0001;
                  if (hit) begin
                     next_r.secs = word_at(bin_interval_seconds_i, bin);
                     next_r.cnt[bin*16 +: 16] = word_at(r.cnt, bin) + 16'h0001;
                     if (bin_store_i[bin]) begin
                        next_r.we    = 1'b1;
                        next_r.data  = temp_i;
                        next_r.nsamp = r.nsamp + 16'h0001;
                        if (bin_stamp_i[bin]) begin
                           next_r.swe   = 1'b1;
                           next_r.stamp = r.now;
                        end
                        if (r.nsamp == 16'(DEPTH - 1)) begin
                           next_r.full = 1'b1;
                           next_r.st   = HTL_SLEEP;
                        end
                     end
                  end
                  if (battery_level_i == BAT_LOW) begin
                     next_r.st = HTL_SLEEP;
                  end
               end
            end
         end
         HTL_SLEEP: begin
            next_r.st = HTL_SLEEP;
         end
         default: begin
            next_r.st = HTL_INACTIVE;
         end
      endcase
      for (int i = 0; i < NB; i++) begin
         if (next_r.cnt[i*16 +: 16] > bin_threshold_i[i*16 +: 16]) begin
            next_r.balarm[i] = 1'b1;
         end
      end
      if (next_r.balarm != '0) begin
         next_r.halarm = 1'b1;
      end
      if (ctrl_reset_i && init_date_i != 32'h0000_0000) begin
         // Activation cancels a sample of the same cycle
         next_r.sub    = '0;
         next_r.req    = 1'b0;
         next_r.we     = 1'b0;
         next_r.swe    = 1'b0;
         next_r.st     = HTL_IDLE;
         next_r.now    = init_date_i;
         next_r.full   = 1'b0;
         next_r.halarm = 1'b0;
         next_r.balarm = '0;
         next_r.cnt    = '0;
         next_r.nsamp  = WORD_ZERO;
         next_r.last   = WORD_ZERO;
         next_r.secs   = WORD_ZERO;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         r     <= '0;
         r.st  <= HTL_INACTIVE;
         r.bat <= BAT_FULL;
      end else begin
         r <= next_r;
      end
   end

   assign temp_req_o             = r.req;
   assign log_we_o               = r.we;
   assign log_data_o             = r.data;
   assign log_stamp_we_o         = r.swe;
   assign log_stamp_o            = r.stamp;
   assign samples_num_o          = r.nsamp;
   assign status_o               = {11'h000, r.halarm, 1'b0, r.full,
                                    r.bat[ST_BAT_HI], r.bat[ST_BAT_LO]};
   assign histogram_alarm_word_o = r.balarm;
   assign bin_counter_o          = r.cnt;
   assign last_sample_o          = r.last;
   assign state_o                = r.st;
endmodule

/* logic/htl_pkg.sv */
// Constants and types shared by the histogram temperature logger
package htl_pkg;
   localparam int          NUM_BINS      = 16;
   localparam int          WORD_W        = 16;
   localparam int          FRAC_BITS     = 5;
   localparam int          INT_BITS      = 8;
   localparam int          FIX_W         = INT_BITS + FRAC_BITS;
   localparam int          LOG_DEPTH     = 4000;
   localparam int          CLK_HZ        = 10_000_000;
   localparam int          SEC_NS        = 1_000_000_000;
   localparam int          CLK_PERIOD_NS = 100;
   localparam int          CYC_PER_SEC   = SEC_NS / CLK_PERIOD_NS;
   localparam logic [1:0]  BAT_FULL      = 2'h3;
   localparam logic [1:0]  BAT_LOW       = 2'h1;
   localparam logic [15:0] WORD_ZERO     = 16'h0000;
   localparam int          ST_BAT_LO     = 0;
   localparam int          ST_BAT_HI     = 1;
   localparam int          ST_MEM_FULL   = 2;
   localparam int          ST_HIST_ALARM = 4;
   typedef enum logic [2:0] {
      HTL_INACTIVE,
      HTL_IDLE,
      HTL_DELAY,
      HTL_ACQUIRE,
      HTL_SLEEP
   } htl_state_t;
endpackage

/* logic/htl_bin_classify.sv */
// Combinational bin lookup for one temperature sample
`timescale 1ns/1ps
module htl_bin_classify #(
   parameter int NB = 16,
   parameter int W  = 16
) (
   input  wire logic signed [W-1:0]  sample_i,
   input  wire logic [NB*W-1:0]      limits_i,
   input  wire logic [NB-1:0]        enable_i,
   output logic                      hit_o,
   output logic [$clog2(NB)-1:0]     bin_o
);
   import htl_pkg::*;

   logic signed [W-1:0] lim;
   logic signed [W-1:0] val;
   logic                found;

   // Word must hold the whole 8.5 field
   if (W < FIX_W) $error("W too narrow for 8.5 values");

   // sign sits at the top of the 8.5 field
   function automatic logic signed [W-1:0] fix_val(input logic [W-1:0] v);
      fix_val = W'(signed'(v[FIX_W-1:0]));
   endfunction

   // first enabled bin with sample <= limit
   always_comb begin
      found = 1'b0;
      bin_o = '0;
      lim   = '0;
      val   = fix_val(sample_i);
      for (int i = 0; i < NB; i++) begin
         lim = fix_val(limits_i[i*W +: W]);
         if (!found && enable_i[i] && val <= lim) begin
            found = 1'b1;
            bin_o = ($clog2(NB))'(i);
         end
      end
      hit_o = found;
   end
endmodule

/* tb/htl_logger_asserts.sv */
// Port assertions for the logger
`timescale 1ns/1ps
module htl_logger_asserts
   import htl_pkg::*;
#(
   parameter int NB = 16
) (
   input  wire logic               ref_clk_i,
   input  wire logic               rst_i,
   input  wire logic [31:0]        init_date_i,
   input  wire logic               ctrl_reset_i,
   input  wire logic [1:0]         battery_level_i,
   input  wire logic signed [15:0] temp_i,
   input  wire logic               temp_req_o,
   input  wire logic               log_we_o,
   input  wire logic               log_stamp_we_o,
   input  wire logic [15:0]        status_o,
   input  wire logic [NB-1:0]      histogram_alarm_word_o,
   input  wire logic [15:0]        last_sample_o,
   input  wire logic [2:0]         state_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   wire logic act = ctrl_reset_i && (init_date_i != 32'h0000_0000);
   property p_act; act |=> state_o == HTL_IDLE; endproperty
   a_act: assert property (p_act) else $error("no idle");
   property p_zero; ctrl_reset_i && !act && state_o == HTL_INACTIVE
      |=> state_o == HTL_INACTIVE; endproperty
   a_zero: assert property (p_zero) else $error("zero date");
   property p_idle; state_o == HTL_IDLE |-> !temp_req_o; endproperty
   a_idle: assert property (p_idle) else $error("idle sample");
   property p_delay; state_o == HTL_DELAY |-> !temp_req_o; endproperty
   a_delay: assert property (p_delay) else $error("delay sample");
   property p_store; log_we_o |-> temp_req_o; endproperty
   a_store: assert property (p_store) else $error("stray store");
   property p_stamp; log_stamp_we_o |-> log_we_o; endproperty
   a_stamp: assert property (p_stamp) else $error("stray stamp");
   property p_alarm; |histogram_alarm_word_o |-> ##[0:1]
      status_o[ST_HIST_ALARM]; endproperty
   a_alarm: assert property (p_alarm) else $error("no summary");
   property p_full; $rose(status_o[ST_MEM_FULL]) |-> ##[0:2]
      state_o == HTL_SLEEP; endproperty
   a_full: assert property (p_full) else $error("no sleep");
   property p_sleep; state_o == HTL_SLEEP && !act |=> state_o == HTL_SLEEP;
   endproperty
   a_sleep: assert property (p_sleep) else $error("left sleep");
   property p_bat; !$stable(battery_level_i) |=>
      status_o[1:0] == $past(battery_level_i); endproperty
   a_bat: assert property (p_bat) else $error("battery");
   property p_last; temp_req_o |-> last_sample_o == $past(temp_i); endproperty
   a_last: assert property (p_last) else $error("last sample");
endmodule
bind htl_logger htl_logger_asserts #(.NB(NB)) u_asserts (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .init_date_i(init_date_i),
   .ctrl_reset_i(ctrl_reset_i), .battery_level_i(battery_level_i),
   .temp_i(temp_i), .temp_req_o(temp_req_o), .log_we_o(log_we_o),
   .log_stamp_we_o(log_stamp_we_o), .status_o(status_o),
   .histogram_alarm_word_o(histogram_alarm_word_o),
   .last_sample_o(last_sample_o), .state_o(state_o));

/* tb/htl_reader.sv */
// Reader model: activation writes and four bin words
`timescale 1ns/1ps
module htl_reader (
   input  wire logic ref_clk_i,
   output logic        ctrl_reset_o,
   output logic [31:0] init_date_o,
   output logic [63:0] bin_upper_limit_o,
   output logic [63:0] bin_threshold_o,
   output logic [63:0] bin_interval_seconds_o
);
   assign bin_upper_limit_o = 64'h08C0_0000_1EC0_1E20;
   assign bin_threshold_o = 64'h0001_0002_0003_0000;
   assign bin_interval_seconds_o = 64'h0003_0001_0002_0001;
   initial begin
      ctrl_reset_o = 1'b0;
      init_date_o = 32'h0000_0000;
   end
   task automatic activate(input logic [31:0] date);
      @(negedge ref_clk_i);
      init_date_o = date;
      @(negedge ref_clk_i);
      ctrl_reset_o = 1'b1;
      @(negedge ref_clk_i);
      ctrl_reset_o = 1'b0;
   endtask
endmodule

/* tb/tb_htl_logger.sv */
// Self-checking bench for the logger
`timescale 1ns/1ps
module tb_htl_logger;
   import htl_pkg::*;
   localparam int NB = 4;
   localparam int CS = 4;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, len = 1'b0, den = 1'b0;
   logic [15:0] sdel = 16'h0000;
   logic [NB-1:0] ben = 4'hB, bst = 4'hE, bts = 4'h8, alarm;
   logic [1:0] bat = 2'h3;
   logic signed [15:0] temp = 16'h1E20;
   logic ctrl_reset, req, we, swe;
   logic [31:0] date, stamp;
   logic [63:0] lim, thr, ivl, cnt;
   logic [15:0] ldat, snum, status, last;
   logic [2:0] state;
   int failures = 0, checks_done = 0, cyc = 0, prev = 0, t0 = 0;
   always #50 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) cyc <= cyc + 1;
   htl_reader u_rdr (.ref_clk_i(ref_clk_i), .ctrl_reset_o(ctrl_reset),
      .init_date_o(date), .bin_upper_limit_o(lim), .bin_threshold_o(thr),
      .bin_interval_seconds_o(ivl));
   htl_logger #(.NB(NB), .DEPTH(4), .CYC_SEC(CS)) u_dut (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .init_date_i(date),
      .ctrl_reset_i(ctrl_reset), .logging_enable_bit_i(len),
      .delay_enable_i(den), .start_delay_s_i(sdel), .bin_enable_i(ben),
      .bin_store_i(bst), .bin_stamp_i(bts), .bin_upper_limit_i(lim),
      .bin_threshold_i(thr), .bin_interval_seconds_i(ivl),
      .battery_level_i(bat), .temp_i(temp), .temp_req_o(req),
      .log_we_o(we), .log_data_o(ldat), .log_stamp_we_o(swe),
      .log_stamp_o(stamp), .samples_num_o(snum), .status_o(status),
      .histogram_alarm_word_o(alarm), .bin_counter_o(cnt),
      .last_sample_o(last), .state_o(state));
   task automatic chk(input string n, input logic [63:0] s, e);
      checks_done++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Sample set before the wait, pulse read on its own cycle
   task automatic smp(input logic [15:0] t, input logic w, ts, input int g);
      int n;
      n = 0;
      temp = t;
      @(negedge ref_clk_i);
      while (req !== 1'b1 && n < 100) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk("gap", (g == 0) ? 0 : cyc - prev, g);
      prev = cyc;
      chk("store", we, w);
      chk("stamp", swe, w & ts);
      if (w) chk("data", ldat, t);
      if (w & ts)
         chk("time", stamp, 32'h0000_0100 + (cyc - t0 - 1) / CS);
      chk("last", last, t);
   endtask
   initial begin
      repeat (3000) @(posedge ref_clk_i);
      failures++;
      $display("watchdog expired");
      results();
   end
   initial begin
      repeat (20) @(negedge ref_clk_i);
      rst_i = 1'b0;
      chk("reset status", status, 16'h0003);
      u_rdr.activate(32'h0000_0000);
      @(negedge ref_clk_i);
      chk("zero date", state, HTL_INACTIVE);
      u_rdr.activate(32'h0000_0100);
      t0 = cyc;
      chk("active", state, HTL_IDLE);
      repeat (12) @(negedge ref_clk_i);
      chk("idle", state, HTL_IDLE);
      $display("activation test done");
      len = 1'b1;
      @(negedge ref_clk_i);
      chk("run", state, HTL_ACQUIRE);
      smp(16'h1E20, 1'b0, 1'b0, 0);
      @(negedge ref_clk_i);
      chk("status", status, 16'h0013);
      // Bin 2 disabled, so -5 lands in bin 3
      smp(16'h1EC0, 1'b1, 1'b0, CS);
      smp(16'h1F60, 1'b1, 1'b1, 2 * CS);
      smp(16'h0900, 1'b0, 1'b0, 3 * CS);
      smp(16'h08C0, 1'b1, 1'b1, CS);
      chk("counters", cnt, 64'h0002_0000_0001_0001);
      chk("alarms", alarm, 4'h9);
      chk("count", snum, 16'h0003);
      smp(16'h0000, 1'b1, 1'b1, 3 * CS);
      repeat (3) @(negedge ref_clk_i);
      chk("full", status, 16'h0017);
      repeat (20) @(negedge ref_clk_i);
      chk("sleep", state, HTL_SLEEP);
      $display("acquisition test done");
      len = 1'b0;
      den = 1'b1;
      sdel = 16'h0002;
      u_rdr.activate(32'h0000_0200);
      chk("cleared", cnt, 64'h0000_0000_0000_0000);
      chk("cleared status", status, 16'h0003);
      len = 1'b1;
      t0 = cyc;
      @(negedge ref_clk_i);
      chk("delay", state, HTL_DELAY);
      smp(16'h1E20, 1'b0, 1'b0, 0);
      chk("delay span", (cyc - t0) >= 2 * CS, 1'b1);
      bat = 2'h2;
      repeat (2) @(negedge ref_clk_i);
      chk("battery", status[1:0], 2'h2);
      // Level one sends the logger to sleep after its next sample
      bat = 2'h1;
      smp(16'h1E20, 1'b0, 1'b0, CS);
      chk("low battery", state, HTL_SLEEP);
      chk("level low", status[1:0], 2'h1);
      $display("delay test done");
      results();
   end
endmodule
